/* hdl/daisy_pkg.sv */
`default_nettype none
package daisy_pkg;
  // ==========================================================
  // Command and packet bytes
  localparam logic [7:0] BCAST_WR_CMD = 8'h02;
  localparam logic [7:0] BCAST_RD_CMD = 8'h03;
  localparam logic [2:0] ADDR_WR_TAG = 3'h4;
  localparam logic [7:0] FILL_EVEN = 8'hC2;
  localparam logic [7:0] FILL_ODD = 8'hD3;
  localparam logic [7:0] DATA_CHECK = 8'h00;
  localparam logic [7:0] PEC_POLY = 8'hA6;
  localparam logic [7:0] PEC_SEED = 8'h00;
  // ==========================================================
  // Byte positions counted from the first byte after the preamble
  localparam logic [7:0] IDX_CMD = 8'h00;
  localparam logic [7:0] IDX_REG = 8'h01;
  localparam logic [7:0] IDX_LO = 8'h02;
  localparam logic [7:0] IDX_HI = 8'h03;
  localparam logic [7:0] WR_PEC_IDX = 8'h04;
  localparam logic [7:0] RD_PEC_BASE = 8'h03;
  localparam logic [7:0] INSERT_SHIFT = 8'h02;
  // ==========================================================
  // Host byte pacing
  localparam int CLK_PERIOD_NS = 100;
  localparam int BYTE_TIME_NS = 5000;
  localparam logic [7:0] BYTE_CYCLES = 8'(BYTE_TIME_NS / CLK_PERIOD_NS);
  // ==========================================================
  // Host register map (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_REGADDR = 8'h08;
  localparam logic [7:0] OFS_WDATA = 8'h0C;
  localparam logic [7:0] OFS_DEVCNT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_RXIDX = 8'h18;
  localparam logic [7:0] OFS_RXBYTE = 8'h1C;
  localparam int RX_DEPTH = 16;
  // Host command kinds held in CTRL[2:1].
  localparam logic [1:0] KIND_BWR = 2'h0;
  localparam logic [1:0] KIND_AWR = 2'h1;
  localparam logic [1:0] KIND_BRD = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b10,
    ST_PASS = 2'b11
  } dev_state_e;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_PRE = 2'b01,
    H_BYTES = 2'b10,
    H_STOP = 2'b11
  } host_state_e;

  // One byte of the packet check, most significant bit first.
  function automatic logic [7:0] pec_step(input logic [7:0] crc,
                                          input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ PEC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // Position of the check byte in a read packet entering a device
  // that has the given number of devices between it and the host.
  function automatic logic [7:0] rd_pec_idx(input logic [5:0] depth);
    return RD_PEC_BASE + {1'b0, depth, 1'b0};
  endfunction
endpackage
`default_nettype wire

/* hdl/daisy_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface daisy_link_if;
  // Host towards device.
  logic h2d_pre;
  logic h2d_vld;
  logic [7:0] h2d_dat;
  logic h2d_cerr;
  logic h2d_stp;
  // Device towards host.
  logic d2h_pre;
  logic d2h_vld;
  logic [7:0] d2h_dat;
  logic d2h_cerr;
  logic d2h_stp;

  modport dev_mp (
    input h2d_pre, h2d_vld, h2d_dat, h2d_cerr, h2d_stp,
    output d2h_pre, d2h_vld, d2h_dat, d2h_cerr, d2h_stp
  );
  modport host_mp (
    output h2d_pre, h2d_vld, h2d_dat, h2d_cerr, h2d_stp,
    input d2h_pre, d2h_vld, d2h_dat, d2h_cerr, d2h_stp
  );
endinterface
`default_nettype wire

/* hdl/daisy_dev.sv */
// Contract
// - broadcast write 02h loads 16-bit value
// - unknown register address: payload ignored
// - write on good check, or at stop
// - bad check: no write, still forward
// - check covers four bytes after preamble
// - bad check sets path and summary flags
// - single link: up flag; dual: by path
// - write packet layout, forwarded unchanged
// - addressed write: own address plus 100b
// - only addressed device flags addressed writes
// - alive byte present only when enabled
// - broadcast read 03h collects every device
// - read check error flagged, packet forwarded
// - coding error: switch to pass-through
// - host read packet with alternating fills
// - insert own data after address, drop fills
// - read length constant along chain
// - first device data reaches host last
// - depth from top, bottom, own addresses
// - host fills alternate, order kept
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module daisy_dev (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Link
  daisy_link_if.dev_mp link,
  // Configuration
  input wire logic [4:0] own_device_addr_i,
  input wire logic [4:0] top_addr_i,
  input wire logic [4:0] bottom_addr_i,
  input wire logic dual_link_i,
  input wire logic down_path_i,
  input wire logic crc_check_disable_i,
  // Register file access
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  input wire logic reg_exists_i,
  input wire logic [15:0] reg_rdata_i,
  // Status flags
  input wire logic [2:0] flag_clr_i,
  output logic crc_err_up_flag_o,
  output logic crc_err_down_flag_o,
  output logic crc_err_summary_flag_o
);
  daisy_pkg::dev_state_e state;
  logic [7:0] idx;
  logic [7:0] crc_rx;
  logic [7:0] crc_tx;
  logic [7:0] lo_byte;
  logic [7:0] own_hi;
  logic [7:0] dly0;
  logic [7:0] dly1;
  logic [5:0] depth;
  logic [7:0] pec_in_idx;
  logic [7:0] pec_out_idx;
  logic [7:0] next_tx;
  logic crc_bad;
  logic set_err;
  logic in_byte;

  // ==========================================================
  // Position decode
  assign in_byte = link.h2d_vld;
  // Devices already passed by a read decide where the check sits.
  always_comb
  begin
    if (down_path_i)
      depth = {1'b0, top_addr_i - own_device_addr_i};
    else
      depth = {1'b0, own_device_addr_i - bottom_addr_i};
  end
  assign pec_in_idx = (state == daisy_pkg::ST_READ) ?
                      daisy_pkg::rd_pec_idx(depth) :
                      daisy_pkg::WR_PEC_IDX;
  assign pec_out_idx = pec_in_idx + daisy_pkg::INSERT_SHIFT;
  assign crc_bad = link.h2d_dat != crc_rx;
  assign set_err = in_byte && idx == pec_in_idx && crc_bad &&
                   !crc_check_disable_i &&
                   (state == daisy_pkg::ST_WRITE ||
                    state == daisy_pkg::ST_READ);

  // ==========================================================
  // Outgoing byte selection
  always_comb
  begin
    next_tx = link.h2d_dat;
    if (state == daisy_pkg::ST_READ && !link.h2d_cerr)
    begin
      if (idx == daisy_pkg::IDX_LO)
        next_tx = reg_exists_i ? reg_rdata_i[7:0] : 8'h00;
      else if (idx == daisy_pkg::IDX_HI)
        next_tx = own_hi;
      else if (idx == pec_out_idx)
        next_tx = crc_tx;
      else if (idx > daisy_pkg::IDX_HI)
        next_tx = dly1;
    end
  end

  // ==========================================================
  // Packet state
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || link.h2d_pre || link.h2d_stp)
      state <= daisy_pkg::ST_IDLE;
    else if (in_byte && idx == daisy_pkg::IDX_CMD)
    begin
      if (link.h2d_dat == daisy_pkg::BCAST_WR_CMD)
        state <= daisy_pkg::ST_WRITE;
      else if (link.h2d_dat == daisy_pkg::BCAST_RD_CMD)
        state <= daisy_pkg::ST_READ;
      else if (link.h2d_dat[2:0] == daisy_pkg::ADDR_WR_TAG &&
               link.h2d_dat[7:3] == own_device_addr_i)
        state <= daisy_pkg::ST_WRITE;
      else
        state <= daisy_pkg::ST_PASS;
    end
    else if (in_byte && link.h2d_cerr &&
             state == daisy_pkg::ST_READ)
      state <= daisy_pkg::ST_PASS;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || link.h2d_pre)
      idx <= 8'h00;
    else if (in_byte && idx != 8'hFF)
      idx <= idx + 8'h01;
  end

  // ==========================================================
  // Check byte accumulation
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || link.h2d_pre)
      crc_rx <= daisy_pkg::PEC_SEED;
    else if (in_byte && idx < pec_in_idx)
      crc_rx <= daisy_pkg::pec_step(crc_rx, link.h2d_dat);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || link.h2d_pre)
      crc_tx <= daisy_pkg::PEC_SEED;
    else if (in_byte && idx < pec_out_idx)
      crc_tx <= daisy_pkg::pec_step(crc_tx, next_tx);
  end

  // ==========================================================
  // Two-byte delay that makes room for the inserted data
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      dly0 <= 8'h00;
      dly1 <= 8'h00;
      own_hi <= 8'h00;
    end
    else if (in_byte)
    begin
      dly0 <= link.h2d_dat;
      dly1 <= dly0;
      if (idx == daisy_pkg::IDX_LO)
        own_hi <= reg_exists_i ? reg_rdata_i[15:8] : 8'h00;
    end
  end

  // ==========================================================
  // Register write path
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      reg_addr_o <= 8'h00;
      lo_byte <= 8'h00;
      reg_wdata_o <= 16'h0000;
    end
    else if (in_byte && state != daisy_pkg::ST_PASS)
    begin
      if (idx == daisy_pkg::IDX_REG)
        reg_addr_o <= link.h2d_dat;
      if (idx == daisy_pkg::IDX_LO)
        lo_byte <= link.h2d_dat;
      if (idx == daisy_pkg::IDX_HI && state == daisy_pkg::ST_WRITE)
        reg_wdata_o <= {link.h2d_dat, lo_byte};
    end
  end

  // Without checking, the write waits for the stop of a packet that
  // reached at least its check byte; the alive byte is not needed.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      reg_wr_o <= 1'b0;
    else if (state != daisy_pkg::ST_WRITE || !reg_exists_i)
      reg_wr_o <= 1'b0;
    else if (crc_check_disable_i)
      reg_wr_o <= link.h2d_stp && idx > daisy_pkg::WR_PEC_IDX;
    else
      reg_wr_o <= in_byte && idx == daisy_pkg::WR_PEC_IDX &&
                  !crc_bad;
  end

  // ==========================================================
  // Status flags; a new error wins over a clear in the same cycle
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      crc_err_up_flag_o <= 1'b0;
      crc_err_down_flag_o <= 1'b0;
      crc_err_summary_flag_o <= 1'b0;
    end
    else
    begin
      if (set_err && !(dual_link_i && down_path_i))
        crc_err_up_flag_o <= 1'b1;
      else if (flag_clr_i[0])
        crc_err_up_flag_o <= 1'b0;
      if (set_err && dual_link_i && down_path_i)
        crc_err_down_flag_o <= 1'b1;
      else if (flag_clr_i[1])
        crc_err_down_flag_o <= 1'b0;
      if (set_err)
        crc_err_summary_flag_o <= 1'b1;
      else if (flag_clr_i[2])
        crc_err_summary_flag_o <= 1'b0;
    end
  end

  // ==========================================================
  // Retransmission, one cycle behind the received byte
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      link.d2h_pre <= 1'b0;
      link.d2h_vld <= 1'b0;
      link.d2h_dat <= 8'h00;
      link.d2h_cerr <= 1'b0;
      link.d2h_stp <= 1'b0;
    end
    else
    begin
      link.d2h_pre <= link.h2d_pre;
      link.d2h_vld <= in_byte;
      link.d2h_cerr <= in_byte && link.h2d_cerr;
      link.d2h_stp <= link.h2d_stp;
      if (in_byte)
        link.d2h_dat <= next_tx;
    end
  end
endmodule
`default_nettype wire

/* hdl/daisy_host.sv */
`timescale 1ns/10ps
`default_nettype none
module daisy_host (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Software port
  input wire logic [7:0] sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [31:0] sw_rdata_o,
  // Link
  daisy_link_if.host_mp link
);
  logic [4:0] ctrl;
  logic [7:0] target;
  logic [7:0] reg_sel;
  logic [15:0] wdata;
  logic [7:0] dev_cnt;
  logic [3:0] rx_sel;
  logic [7:0] rx_mem [0:daisy_pkg::RX_DEPTH-1];
  logic [7:0] rx_cnt;
  daisy_pkg::host_state_e state;
  logic [7:0] pace;
  logic [7:0] tx_idx;
  logic [7:0] tx_len;
  logic [7:0] pec_idx;
  logic [7:0] crc;
  logic [7:0] tx_byte;
  logic is_rd;
  logic start;
  logic emit;
  logic last;

  // ==========================================================
  // Software registers
  // CTRL: bit 0 start, bits 2:1 kind, bit 3 coding error, bit 4 bad check.
  assign start = sw_wr_i && sw_addr_i == daisy_pkg::OFS_CTRL &&
                 sw_wdata_i[0] && state == daisy_pkg::H_IDLE;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl <= 5'h00;
      target <= 8'h00;
      reg_sel <= 8'h00;
      wdata <= 16'h0000;
      dev_cnt <= 8'h00;
      rx_sel <= 4'h0;
    end
    else if (sw_wr_i)
    begin
      case (sw_addr_i)
        daisy_pkg::OFS_CTRL:
          if (state == daisy_pkg::H_IDLE)
            ctrl <= sw_wdata_i[4:0];
        daisy_pkg::OFS_TARGET: target <= sw_wdata_i[7:0];
        daisy_pkg::OFS_REGADDR: reg_sel <= sw_wdata_i[7:0];
        daisy_pkg::OFS_WDATA: wdata <= sw_wdata_i[15:0];
        daisy_pkg::OFS_DEVCNT: dev_cnt <= sw_wdata_i[7:0];
        daisy_pkg::OFS_RXIDX: rx_sel <= sw_wdata_i[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || !sw_rd_i)
      sw_rdata_o <= 32'h00000000;
    else
    begin
      case (sw_addr_i)
        daisy_pkg::OFS_CTRL: sw_rdata_o <= {27'h0000000, ctrl};
        daisy_pkg::OFS_STATUS:
          sw_rdata_o <= {31'h00000000, state != daisy_pkg::H_IDLE};
        daisy_pkg::OFS_RXIDX: sw_rdata_o <= {28'h0000000, rx_sel};
        daisy_pkg::OFS_RXBYTE: sw_rdata_o <= {24'h000000, rx_mem[rx_sel]};
        default: sw_rdata_o <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Packet contents
  assign is_rd = ctrl[2:1] == daisy_pkg::KIND_BRD;
  assign pec_idx = is_rd ? daisy_pkg::RD_PEC_BASE : daisy_pkg::WR_PEC_IDX;
  assign tx_len = pec_idx + 8'h01 +
                  (is_rd ? {dev_cnt[6:0], 1'b0} : 8'h00);
  assign emit = state == daisy_pkg::H_BYTES &&
                pace == daisy_pkg::BYTE_CYCLES - 8'h01;
  assign last = tx_idx == tx_len - 8'h01;

  always_comb
  begin
    tx_byte = daisy_pkg::DATA_CHECK;
    if (tx_idx == pec_idx)
      tx_byte = ctrl[4] ? ~crc : crc;
    else if (tx_idx > pec_idx)
      tx_byte = tx_idx[0] ? daisy_pkg::FILL_ODD :
                daisy_pkg::FILL_EVEN;
    else if (tx_idx == daisy_pkg::IDX_CMD)
    begin
      if (is_rd)
        tx_byte = daisy_pkg::BCAST_RD_CMD;
      else if (ctrl[2:1] == daisy_pkg::KIND_AWR)
        tx_byte = {target[4:0], daisy_pkg::ADDR_WR_TAG};
      else
        tx_byte = daisy_pkg::BCAST_WR_CMD;
    end
    else if (tx_idx == daisy_pkg::IDX_REG)
      tx_byte = reg_sel;
    else if (!is_rd && tx_idx == daisy_pkg::IDX_LO)
      tx_byte = wdata[7:0];
    else if (!is_rd && tx_idx == daisy_pkg::IDX_HI)
      tx_byte = wdata[15:8];
  end

  // ==========================================================
  // Sequencer: preamble, paced bytes, stop
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      state <= daisy_pkg::H_IDLE;
    else
    begin
      case (state)
        daisy_pkg::H_IDLE:
          if (start)
            state <= daisy_pkg::H_PRE;
        daisy_pkg::H_PRE: state <= daisy_pkg::H_BYTES;
        daisy_pkg::H_BYTES:
          if (emit && last)
            state <= daisy_pkg::H_STOP;
        daisy_pkg::H_STOP: state <= daisy_pkg::H_IDLE;
        default: state <= daisy_pkg::H_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || state != daisy_pkg::H_BYTES || emit)
      pace <= 8'h00;
    else
      pace <= pace + 8'h01;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || start)
      tx_idx <= 8'h00;
    else if (emit)
      tx_idx <= tx_idx + 8'h01;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || start)
      crc <= daisy_pkg::PEC_SEED;
    else if (emit && tx_idx < pec_idx)
      crc <= daisy_pkg::pec_step(crc, tx_byte);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      link.h2d_pre <= 1'b0;
      link.h2d_vld <= 1'b0;
      link.h2d_dat <= 8'h00;
      link.h2d_cerr <= 1'b0;
      link.h2d_stp <= 1'b0;
    end
    else
    begin
      link.h2d_pre <= start;
      link.h2d_vld <= emit;
      link.h2d_stp <= state == daisy_pkg::H_STOP;
      link.h2d_cerr <= emit && ctrl[3] && is_rd &&
                       tx_idx == daisy_pkg::IDX_LO;
      if (emit)
        link.h2d_dat <= tx_byte;
    end
  end

  // ==========================================================
  // Returned bytes, counted from the first byte after the preamble
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || link.d2h_pre)
      rx_cnt <= 8'h00;
    else if (link.d2h_vld && rx_cnt < 8'(daisy_pkg::RX_DEPTH))
    begin
      rx_mem[rx_cnt[3:0]] <= link.d2h_dat;
      rx_cnt <= rx_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* bench/daisy_link_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module daisy_link_asserts (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Host to device
  input wire logic h2d_pre,
  input wire logic h2d_vld,
  input wire logic [7:0] h2d_dat,
  input wire logic h2d_cerr,
  input wire logic h2d_stp,
  // Device to host
  input wire logic d2h_pre,
  input wire logic d2h_vld,
  input wire logic [7:0] d2h_dat,
  input wire logic d2h_cerr,
  input wire logic d2h_stp
);
  // ==========================================================
  // Byte positions and the first host bytes of each packet
  logic [7:0] h_cnt;
  logic [7:0] d_cnt;
  logic [7:0] h_len;
  logic [7:0] h_b [0:3];
  logic is_rd;

  assign is_rd = (h_b[0] == daisy_pkg::BCAST_RD_CMD);

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || h2d_pre)
      h_cnt <= 8'h00;
    else if (h2d_vld)
      h_cnt <= h_cnt + 8'h01;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || d2h_pre)
      d_cnt <= 8'h00;
    else if (d2h_vld)
      d_cnt <= d_cnt + 8'h01;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (h2d_vld && h_cnt < 8'h04)
      h_b[h_cnt[1:0]] <= h2d_dat;
    if (h2d_stp)
      h_len <= h_cnt;
  end

  // ==========================================================
  // Checks on the link
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_cmd_byte_kept: assert property (d2h_vld && d_cnt == 8'h00 |-> d2h_dat == h_b[0]) else $error("command byte changed");
  a_wr_bytes_kept: assert property (d2h_vld && d_cnt < 8'h04 && !is_rd |-> d2h_dat == h_b[d_cnt[1:0]]) else $error("write byte changed");
  a_len_kept: assert property ($rose(d2h_stp) |-> d_cnt == h_len) else $error("packet length changed");
  a_stop_follows: assert property ($rose(h2d_stp) |-> ##[0:200] d2h_stp) else $error("packet not forwarded");
  a_pre_follows: assert property ($rose(h2d_pre) |-> ##[0:200] d2h_pre) else $error("preamble not forwarded");
  a_cerr_passes: assert property (h2d_vld && h2d_cerr |-> ##1 d2h_cerr) else $error("coding error not passed");
  a_pre_quiet: assert property (d2h_pre |-> !d2h_vld && !d2h_stp) else $error("byte during preamble");
  a_stop_clean: assert property (d2h_vld |-> !d2h_stp) else $error("byte during stop");

  cover property ($rose(d2h_stp) && is_rd);
  cover property ($rose(d2h_stp) && h_b[0] == daisy_pkg::BCAST_WR_CMD);
  cover property ($rose(d2h_stp) && h_b[0][2:0] == daisy_pkg::ADDR_WR_TAG);
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h00000000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic crc_off = 1'b0;
  logic [2:0] flag_clr = 3'h0;
  logic [1:0] inj = 2'h0;
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [2:0] flags;
  logic [7:0] wr_a;
  logic [15:0] wr_d;
  int wr_n = 0;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #50 core_clk_i = ~core_clk_i;

  daisy_link_if daisy_link_if_i ();
  daisy_host daisy_host_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr),
    .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata), .link(daisy_link_if_i.host_mp));
  daisy_dev daisy_dev_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .link(daisy_link_if_i.dev_mp), .own_device_addr_i(5'h03),
    .top_addr_i(5'h03), .bottom_addr_i(5'h03), .dual_link_i(1'b0),
    .down_path_i(1'b0), .crc_check_disable_i(crc_off), .reg_wr_o(reg_wr),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_exists_i(reg_addr < 8'h40), .reg_rdata_i({reg_addr, ~reg_addr}),
    .flag_clr_i(flag_clr), .crc_err_up_flag_o(flags[0]),
    .crc_err_down_flag_o(flags[1]), .crc_err_summary_flag_o(flags[2]));
  daisy_link_asserts daisy_link_asserts_i (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .h2d_pre(daisy_link_if_i.h2d_pre),
    .h2d_vld(daisy_link_if_i.h2d_vld), .h2d_dat(daisy_link_if_i.h2d_dat),
    .h2d_cerr(daisy_link_if_i.h2d_cerr), .h2d_stp(daisy_link_if_i.h2d_stp),
    .d2h_pre(daisy_link_if_i.d2h_pre), .d2h_vld(daisy_link_if_i.d2h_vld),
    .d2h_dat(daisy_link_if_i.d2h_dat), .d2h_cerr(daisy_link_if_i.d2h_cerr),
    .d2h_stp(daisy_link_if_i.d2h_stp));

  // ==========================================================
  // Register file stand-in records every write
  always @(posedge core_clk_i)
  begin
    if (reg_wr === 1'b1)
    begin
      wr_n++;
      wr_a <= reg_addr;
      wr_d <= reg_wdata;
    end
  end

  task automatic summarize;
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A hung packet must not stall the run forever.
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge core_clk_i);
    sw_wr <= 1'b0;
  endtask

  task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk_i);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask

  task automatic run(input logic [1:0] kind, input logic [7:0] tgt,
                     input logic [7:0] ra, input logic [15:0] d);
    int n;
    sw_write(daisy_pkg::OFS_TARGET, 32'(tgt));
    sw_write(daisy_pkg::OFS_REGADDR, 32'(ra));
    sw_write(daisy_pkg::OFS_WDATA, 32'(d));
    sw_write(daisy_pkg::OFS_DEVCNT, 32'h00000001);
    sw_write(daisy_pkg::OFS_CTRL, 32'({inj, kind, 1'b1}));
    n = 0;
    while (daisy_link_if_i.d2h_stp !== 1'b1 && n < 5000)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    check(32'(n == 5000), 32'h00000000);
    repeat (5) @(posedge core_clk_i);
  endtask

  task automatic t_write(input logic [1:0] kind, input logic [7:0] tgt,
                         input logic [7:0] ra, input logic [15:0] d,
                         input int exp_n);
    int n0;
    n0 = wr_n;
    run(kind, tgt, ra, d);
    check(32'(wr_n - n0), 32'(exp_n));
    if (exp_n == 1)
    begin
      check(32'(wr_a), 32'(ra));
      check(32'(wr_d), 32'(d));
    end
  endtask

  task automatic rx_check(input logic [3:0] i, input logic [7:0] exp);
    logic [31:0] v;
    sw_write(daisy_pkg::OFS_RXIDX, 32'(i));
    sw_read(daisy_pkg::OFS_RXBYTE, v);
    check(32'(v[7:0]), 32'(exp));
  endtask

  task automatic t_read(input logic [7:0] ra);
    run(daisy_pkg::KIND_BRD, 8'h00, ra, 16'h0000);
    rx_check(4'h2, ~ra);
    rx_check(4'h3, ra);
    rx_check(4'h4, daisy_pkg::DATA_CHECK);
  endtask

  task automatic t_flags;
    inj = 2'h2;
    t_write(daisy_pkg::KIND_BWR, 8'h00, 8'h12, 16'h1111, 0);
    inj = 2'h0;
    check(32'(flags), 32'h00000005);
    flag_clr <= 3'h7;
    @(posedge core_clk_i);
    flag_clr <= 3'h0;
    @(posedge core_clk_i);
    #1;
    check(32'(flags), 32'h00000000);
  endtask

  task automatic t_cerr(input logic [7:0] ra);
    inj = 2'h1;
    run(daisy_pkg::KIND_BRD, 8'h00, ra, 16'h0000);
    inj = 2'h0;
    rx_check(4'h2, daisy_pkg::DATA_CHECK);
    rx_check(4'h4, daisy_pkg::FILL_EVEN);
  endtask

  initial
  begin
    repeat (20) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_write(daisy_pkg::KIND_BWR, 8'h00, 8'h12, 16'hBEEF, 1);
    t_write(daisy_pkg::KIND_BWR, 8'h00, 8'h7F, 16'h1234, 0);
    t_write(daisy_pkg::KIND_AWR, 8'h03, 8'h05, 16'h0A5C, 1);
    t_write(daisy_pkg::KIND_AWR, 8'h06, 8'h05, 16'h5555, 0);
    crc_off <= 1'b1;
    t_write(daisy_pkg::KIND_BWR, 8'h00, 8'h20, 16'hC3E1, 1);
    crc_off <= 1'b0;
    t_read(8'h21);
    t_flags();
    t_cerr(8'h22);
    check(32'(flags), 32'h00000000);
    summarize();
  end
endmodule
`default_nettype wire
